// ===== rtl/soc_output_conditioning.sv
// Output conditioning: input scaling, 16-segment linearizer, output scaling, clamps and setup decode
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps

module soc_output_conditioning #(
    parameter int IS_PWM = 0
) (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic [7:0]         regAddr,
    input  wire logic [31:0]        regWdata,
    input  wire logic               regWr,
    input  wire logic               regRd,
    output logic [31:0]             regRdata,
    input  wire logic [21:0]        filteredSample,
    input  wire logic               diagError,
    input  wire logic               overVoltage,
    input  wire logic               shortDetected,
    output logic [15:0]             outLevel,
    output logic [11:0]             pwmDuty,
    output logic                    pwmFast,
    output soc_pkg::soc_outctl_t    outCtl,
    output soc_pkg::soc_supply_t    supplyTh,
    output logic                    diagFlag,
    output logic                    memLocked
);

    // Only the analog and the PWM variant exist
    if (IS_PWM != 0 && IS_PWM != 1) begin : g_bad_variant
        $error("IS_PWM must be 0 or 1");
    end

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [15:0]          linGain;
        logic [15:0]          linOffset;
        logic [15:0]          outGain;
        logic [15:0]          outOffset;
        logic [15:0]          clampHigh;
        logic [15:0]          clampLow;
        logic [15:0]          custCfg;
        logic [16*16-1:0]     linearization_point;
        logic                 lockAtReset;   // Lock bit seen at power-up
        logic                 armed;         // Capture done after reset
        logic                 diagHeld;
        logic [14:0]          linIn;         // Pipeline stage 1
        logic [15:0]          linOut;        // Pipeline stage 2
        logic [31:0]          rdata;
        logic [15:0]          level;
        logic [11:0]          duty;
        logic                 fast;
        soc_pkg::soc_outctl_t ctl;
        soc_pkg::soc_supply_t sup;
        logic                 flag;
    } soc_state_t;

    soc_state_t st;
    soc_state_t next_st;

    localparam int SEG_BITS_W = soc_pkg::SEG_BITS;

    // Combinational scratch
    logic        [15:0] window;
    logic signed [33:0] scaled;
    logic signed [17:0] satIn;
    logic        [3:0]  seg;
    logic        [SEG_BITS_W-1:0] frac;
    logic signed [16:0] spLo;
    logic signed [16:0] spHi;
    logic signed [29:0] interp;
    logic signed [33:0] outScaled;
    logic signed [17:0] outSat;
    logic               locked;
    logic               diagNow;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        next_st = st;
        locked  = st.custCfg[soc_pkg::CFG_LOCK];

        // Range window out of the 22-bit filtered word
        // Setting n keeps bits 22-n down to 7-n; setting 0 pads the top with zero
        window = 16'(filteredSample >> (soc_pkg::WIN_SHIFT_MAX - st.custCfg[soc_pkg::CFG_SHIFT_L +: 3]));

        // Input scaling, gain is Q1.15
        scaled = 34'($signed(window) * $signed(st.linGain)) + 34'($signed({st.linOffset, 15'h0000}));
        satIn  = 18'(scaled >>> 15);
        // Saturate so interpolation never sees out-of-range values
        if (satIn > soc_pkg::LIN_MAX) begin
            satIn = soc_pkg::LIN_MAX;
        end else if (satIn < soc_pkg::LIN_MIN) begin
            satIn = soc_pkg::LIN_MIN;
        end
        next_st.linIn = satIn[14:0];

        // Linearizer: equal segments, setpoints add to the identity line
        seg  = st.linIn[14:11];
        frac = st.linIn[10:0];
        spLo = (seg == 4'h0) ? 17'sh00000 : 17'($signed(st.linearization_point[16*(seg-4'h1) +: 16]));
        spHi = 17'($signed(st.linearization_point[16*seg +: 16]));
        interp = 30'(spLo) * 30'sd2048 + 30'(spHi - spLo) * 30'($signed({1'b0, frac}));
        next_st.linOut = 16'(18'($signed({1'b0, st.linIn})) + 18'(interp >>> soc_pkg::SEG_BITS));

        // Output scaling and clamping
        outScaled = 34'($signed(st.linOut) * $signed(st.outGain))
                  + 34'($signed({st.outOffset, 15'h0000}));
        outSat = 18'(outScaled >>> 15);
        if (outSat > 18'($signed(st.clampHigh))) begin
            outSat = 18'($signed(st.clampHigh));
        end
        if (outSat < 18'($signed(st.clampLow))) begin
            outSat = 18'($signed(st.clampLow));
        end
        next_st.level = outSat[15:0];
        next_st.fast  = (IS_PWM == 1) && st.custCfg[soc_pkg::CFG_RATE_L +: 2] == soc_pkg::RATE_2K;
        next_st.duty  = next_st.fast ? {1'b0, outSat[14:4]} : outSat[14:3];

        // Diagnosis latch holds while CFG_LATCH is set; without it the flag follows the inputs
        diagNow = diagError || (overVoltage && !st.custCfg[soc_pkg::CFG_OVOFF]);
        if (st.custCfg[soc_pkg::CFG_LATCH]) begin
            next_st.diagHeld = st.diagHeld || diagNow;
        end else begin
            next_st.diagHeld = diagNow;
        end
        next_st.flag = next_st.diagHeld;

        // Lock sampled once after reset release gates short detection; custCfg is still cleared then, so it never arms
        if (!st.armed) begin
            next_st.armed       = 1'b1;
            next_st.lockAtReset = locked;
        end

        next_st.ctl.shortMode   = st.custCfg[soc_pkg::CFG_SHORT_L +: 2];
        next_st.ctl.shortActive = st.lockAtReset && st.custCfg[soc_pkg::CFG_SHORT_L +: 2] != soc_pkg::SHORT_OFF;
        next_st.ctl.bandLow     = (IS_PWM == 0) && locked && st.custCfg[soc_pkg::CFG_BAND];
        next_st.ctl.pwmInvert   = (IS_PWM == 1) && locked && st.custCfg[soc_pkg::CFG_BAND];
        next_st.ctl.errForce    = !st.custCfg[soc_pkg::CFG_DIAGOFF]
                                  && (st.diagHeld || (shortDetected && st.ctl.shortActive));
        next_st.ctl.commEnable  = st.custCfg[soc_pkg::CFG_COMM];
        next_st.ctl.ovEnable    = !st.custCfg[soc_pkg::CFG_OVOFF];
        next_st.sup.underMv     = st.custCfg[soc_pkg::CFG_NORMAL] ? soc_pkg::UV_NORM_MV : soc_pkg::UV_EXT_MV;
        next_st.sup.overMv      = st.custCfg[soc_pkg::CFG_NORMAL] ? soc_pkg::OV_NORM_MV : soc_pkg::OV_EXT_MV;

        // Register writes; once locked only the lock stays, memory frozen
        if (regWr && !locked) begin
            case (regAddr)
                soc_pkg::REG_LIN_GAIN:   next_st.linGain   = regWdata[15:0];
                soc_pkg::REG_LIN_OFFSET: next_st.linOffset = regWdata[15:0];
                soc_pkg::REG_OUT_GAIN:   next_st.outGain   = regWdata[15:0];
                soc_pkg::REG_OUT_OFFSET: next_st.outOffset = regWdata[15:0];
                soc_pkg::REG_CLAMP_HIGH: next_st.clampHigh = regWdata[15:0];
                soc_pkg::REG_CLAMP_LOW:  next_st.clampLow  = regWdata[15:0];
                soc_pkg::REG_CUST_CFG:   next_st.custCfg   = {1'b0, regWdata[14:7], 1'b0, regWdata[5:0]};
                default: begin
                    if (regAddr >= soc_pkg::REG_LINEARIZATION_POINT_BASE && regAddr < soc_pkg::REG_SAMPLE
                        && regAddr[1:0] == 2'h0) begin
                        // Index counts from the first setpoint word, not from address zero
                        next_st.linearization_point[16*(4'((regAddr - soc_pkg::REG_LINEARIZATION_POINT_BASE) >> 2))+:16] = regWdata[15:0];
                    end
                end
            endcase
        end

        // Read data valid the cycle after the strobe only
        next_st.rdata = 32'h00000000;
        if (regRd) begin
            case (regAddr)
                soc_pkg::REG_LIN_GAIN:   next_st.rdata = {16'h0000, st.linGain};
                soc_pkg::REG_LIN_OFFSET: next_st.rdata = {16'h0000, st.linOffset};
                soc_pkg::REG_OUT_GAIN:   next_st.rdata = {16'h0000, st.outGain};
                soc_pkg::REG_OUT_OFFSET: next_st.rdata = {16'h0000, st.outOffset};
                soc_pkg::REG_CLAMP_HIGH: next_st.rdata = {16'h0000, st.clampHigh};
                soc_pkg::REG_CLAMP_LOW:  next_st.rdata = {16'h0000, st.clampLow};
                soc_pkg::REG_CUST_CFG:   next_st.rdata = {16'h0000, st.custCfg};
                soc_pkg::REG_SAMPLE:     next_st.rdata = {10'h000, filteredSample};
                soc_pkg::REG_RESULT:     next_st.rdata = {16'h0000, st.level};
                soc_pkg::REG_STATUS:     next_st.rdata = {24'h000000, 4'h0, st.lockAtReset,
                                                           st.ctl.errForce, st.diagHeld, locked};
                default: begin
                    if (regAddr >= soc_pkg::REG_LINEARIZATION_POINT_BASE && regAddr < soc_pkg::REG_SAMPLE
                        && regAddr[1:0] == 2'h0) begin
                        next_st.rdata = {16'h0000, st.linearization_point[16*(4'((regAddr - soc_pkg::REG_LINEARIZATION_POINT_BASE) >> 2))+:16]};
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; reset clears everything, lock is captured after release

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign regRdata  = st.rdata;
    assign outLevel  = st.level;
    assign pwmDuty   = st.duty;
    assign pwmFast   = st.fast;
    assign outCtl    = st.ctl;
    assign supplyTh  = st.sup;
    assign diagFlag  = st.flag;
    assign memLocked = st.custCfg[soc_pkg::CFG_LOCK];

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_diag_seen;
        diagError && st.custCfg[soc_pkg::CFG_LATCH];
    endsequence
    sequence s_diag_gone;
        !diagError && !overVoltage;
    endsequence

    chk_latch_holds: assert property (@(posedge mclk) disable iff (rst)
        s_diag_seen ##1 s_diag_gone |=> diagFlag)
        else $error("latched diagnosis flag dropped");
    chk_lin_range: assert property (@(posedge mclk) disable iff (rst)
        scaled < 34'sh0 |=> st.linIn == 15'h0000)
        else $error("negative linearizer input not held at zero");
    chk_lin_ceiling: assert property (@(posedge mclk) disable iff (rst)
        (scaled >>> 15) > 34'(soc_pkg::LIN_MAX) |=> st.linIn == 15'h7fff)
        else $error("oversized linearizer input not held at ceiling");
    chk_clamp_high: assert property (@(posedge mclk) disable iff (rst)
        $signed(st.clampLow) <= $signed(st.clampHigh) |=> $signed(outLevel) <= $signed($past(st.clampHigh)))
        else $error("output above high clamp");
    chk_clamp_low: assert property (@(posedge mclk) disable iff (rst)
        $signed(st.clampLow) <= $signed(st.clampHigh) |=> $signed(outLevel) >= $signed($past(st.clampLow)))
        else $error("output below low clamp");
    chk_band_unlock: assert property (@(posedge mclk) disable iff (rst)
        !memLocked |=> !outCtl.bandLow)
        else $error("low band while unlocked");
    chk_short_arm: assert property (@(posedge mclk) disable iff (rst)
        outCtl.shortActive |-> st.lockAtReset)
        else $error("short detection without lock at reset");
    chk_lock_freeze: assert property (@(posedge mclk) disable iff (rst)
        memLocked && regWr |=> $stable(st.outGain) && memLocked)
        else $error("write accepted while locked");
    chk_ov_off: assert property (@(posedge mclk) disable iff (rst)
        st.custCfg[soc_pkg::CFG_OVOFF] && !diagError && !st.custCfg[soc_pkg::CFG_LATCH] |=> !st.diagHeld)
        else $error("overvoltage not masked");
    chk_diag_force: assert property (@(posedge mclk) disable iff (rst)
        st.diagHeld && !st.custCfg[soc_pkg::CFG_DIAGOFF] |=> outCtl.errForce)
        else $error("error not forced");
    chk_supply_sel: assert property (@(posedge mclk) disable iff (rst)
        st.custCfg[soc_pkg::CFG_NORMAL] |=> supplyTh.overMv == soc_pkg::OV_NORM_MV)
        else $error("wrong supply threshold");
    chk_supply_ext: assert property (@(posedge mclk) disable iff (rst)
        !st.custCfg[soc_pkg::CFG_NORMAL] |=> supplyTh.underMv == soc_pkg::UV_EXT_MV)
        else $error("wrong extended undervoltage threshold");

    // Setup fields copied to the control word and the PWM rate flag one cycle later
    chk_short_mode: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> outCtl.shortMode == $past(st.custCfg[soc_pkg::CFG_SHORT_L +: 2]))
        else $error("short mode not following setup");
    chk_comm_follow: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> outCtl.commEnable == $past(st.custCfg[soc_pkg::CFG_COMM]))
        else $error("output pin communication not following setup");
    chk_ov_enable: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> outCtl.ovEnable == !$past(st.custCfg[soc_pkg::CFG_OVOFF]))
        else $error("overvoltage enable not following setup");
    chk_rate_fast: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> pwmFast == (IS_PWM == 1 && $past(st.custCfg[soc_pkg::CFG_RATE_L +: 2]) == soc_pkg::RATE_2K))
        else $error("wrong PWM rate mode");

    // Band and polarity only take effect on a locked device; short detection needs the lock at reset; the lock holds until reset
    chk_band_lock: assert property (@(posedge mclk) disable iff (rst)
        memLocked && st.custCfg[soc_pkg::CFG_BAND] && IS_PWM == 0 |=> outCtl.bandLow)
        else $error("low band not selected when locked");
    chk_pol_unlock: assert property (@(posedge mclk) disable iff (rst)
        !memLocked |=> !outCtl.pwmInvert)
        else $error("polarity inverted while unlocked");
    chk_short_idle: assert property (@(posedge mclk) disable iff (rst)
        !st.lockAtReset |=> !outCtl.shortActive)
        else $error("short detection armed without lock at reset");
    chk_lock_sticky: assert property (@(posedge mclk) disable iff (rst)
        memLocked |=> memLocked)
        else $error("lock dropped without reset");

    // Diagnosis capture, following and masking
    chk_diag_catch: assert property (@(posedge mclk) disable iff (rst)
        diagError |=> diagFlag)
        else $error("diagnosis error not flagged");
    chk_ov_detect: assert property (@(posedge mclk) disable iff (rst)
        overVoltage && !st.custCfg[soc_pkg::CFG_OVOFF] |=> st.diagHeld)
        else $error("overvoltage not flagged");
    chk_diag_follow: assert property (@(posedge mclk) disable iff (rst)
        !st.custCfg[soc_pkg::CFG_LATCH] && !diagError && !overVoltage |=> !diagFlag)
        else $error("unlatched flag did not follow");
    chk_diag_off: assert property (@(posedge mclk) disable iff (rst)
        st.custCfg[soc_pkg::CFG_DIAGOFF] |=> !outCtl.errForce)
        else $error("error forced while diagnosis forcing is off");

endmodule

// ===== rtl/soc_pkg.sv
// Package: register map, setup-field layout, output codes and carried types for the output conditioning block
package soc_pkg;

    // Register byte addresses, one aligned word each; index = byte address / 4
    localparam logic [7:0] REG_LIN_GAIN    = 8'h00;
    localparam logic [7:0] REG_LIN_OFFSET  = 8'h04;
    localparam logic [7:0] REG_OUT_GAIN    = 8'h08;
    localparam logic [7:0] REG_OUT_OFFSET  = 8'h0c;
    localparam logic [7:0] REG_CLAMP_HIGH  = 8'h10;
    localparam logic [7:0] REG_CLAMP_LOW   = 8'h14;
    localparam logic [7:0] REG_CUST_CFG    = 8'h18;
    localparam logic [7:0] REG_LINEARIZATION_POINT_BASE  = 8'h20;  // 16 setpoints, 8'h20..8'h5c
    localparam logic [7:0] REG_SAMPLE      = 8'h60;  // Read only: raw sample input
    localparam logic [7:0] REG_RESULT      = 8'h64;  // Read only: conditioned output word
    localparam logic [7:0] REG_STATUS      = 8'h68;  // Read only: live state bits

    // Customer configuration field positions
    localparam int CFG_LOCK    = 0;
    localparam int CFG_DIAGOFF = 1;
    localparam int CFG_LATCH   = 2;
    localparam int CFG_OVOFF   = 3;
    localparam int CFG_COMM    = 4;
    localparam int CFG_NORMAL  = 5;
    localparam int CFG_BAND    = 7;
    localparam int CFG_SHORT_L = 8;
    localparam int CFG_RATE_L  = 10;
    localparam int CFG_SHIFT_L = 12;

    // Range setting 0 takes its window from bit 22 down, each step one bit lower
    localparam logic [2:0] WIN_SHIFT_MAX = 3'h7;

    // Short handling codes
    localparam logic [1:0] SHORT_OFF  = 2'h0;
    localparam logic [1:0] SHORT_HIGH = 2'h1;
    localparam logic [1:0] SHORT_GND  = 2'h2;
    localparam logic [1:0] SHORT_TRI  = 2'h3;

    // PWM rate codes and resolutions
    localparam logic [1:0] RATE_2K    = 2'h3;
    localparam int         RES_FAST   = 11;
    localparam int         RES_NORMAL = 12;

    // Numeric limits
    localparam logic signed [17:0] LIN_MAX  = 18'sh07fff;  // Linearizer input ceiling
    localparam logic signed [17:0] LIN_MIN  = 18'sh00000;
    localparam int                 SEG_BITS = 11;           // 32768 / 16 segments

    // Supply thresholds in millivolts
    localparam logic [15:0] UV_EXT_MV  = 16'h0ed8;  // 3.8 V
    localparam logic [15:0] OV_EXT_MV  = 16'h2328;  // 9 V
    localparam logic [15:0] UV_NORM_MV = 16'h1068;  // 4.2 V
    localparam logic [15:0] OV_NORM_MV = 16'h1770;  // 6 V

    // Output behaviour selection carried as one word
    typedef struct packed {
        logic       errForce;     // Output forced to error mode
        logic       bandLow;      // Error band low when set
        logic       pwmInvert;    // Period starts low when set
        logic       shortActive;  // Short detection armed
        logic [1:0] shortMode;
        logic       commEnable;
        logic       ovEnable;
    } soc_outctl_t;

    typedef struct packed {
        logic [15:0] underMv;
        logic [15:0] overMv;
    } soc_supply_t;

endpackage

// ===== bench/tb.sv
// Self-checking bench for the output conditioning block: registers, setup decode, signal path, lock
`timescale 1ns/1ps
module tb;
    logic                 mclk           = 1'b0;
    logic                 rst            = 1'b1;
    logic [7:0]           regAddr        = 8'h00;
    logic [31:0]          regWdata       = 32'h0;
    logic                 regWr          = 1'b0;
    logic                 regRd          = 1'b0;
    logic [31:0]          regRdata;
    logic [21:0]          filteredSample = 22'h0;
    logic                 diagError      = 1'b0;
    logic                 overVoltage    = 1'b0;
    logic                 shortDetected  = 1'b0;
    logic [15:0]          outLevel;
    soc_pkg::soc_outctl_t outCtl;
    soc_pkg::soc_supply_t supplyTh;
    logic                 diagFlag;
    logic                 memLocked;
    int                   error_cnt      = 0;
    int                   n_checks       = 0;
    int                   seed           = 92;
    int                   cycles         = 0;
    logic signed [15:0]   lg, lo, og, oo, ch, cl;
    logic signed [15:0]   sp [16];

    soc_output_conditioning #(.IS_PWM(0)) soc_output_conditioning_i (
        .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .filteredSample(filteredSample), .diagError(diagError),
        .overVoltage(overVoltage), .shortDetected(shortDetected), .outLevel(outLevel), .pwmDuty(),
        .pwmFast(), .outCtl(outCtl), .supplyTh(supplyTh), .diagFlag(diagFlag), .memLocked(memLocked));

    always #2.5 mclk = ~mclk;

    // Hang guard, generous against the roughly 650 cycles the sequence needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Two idle edges after the strobe so the decoded control outputs have settled before any check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    // Read data stand only in the cycle after the strobe; upper half zero except for the sample word
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [15:0] exp);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 chk(nm, {16'h0000, exp}, regRdata);
        @(posedge mclk);
    endtask

    task automatic doReset();
        rst <= 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Reference path: window, input scaling with saturation, setpoints, output scaling, clamps
    function automatic logic [15:0] expOut(input logic [21:0] smp, input int sh);
        logic signed [47:0] v;
        logic signed [47:0] cs;
        logic signed [47:0] ce;
        int                 k;
        v = signed'(16'(smp >> (7 - sh)));
        v = ((v * lg) >>> 15) + lo;
        if (v < 0) v = 0;
        if (v > 32767) v = 32767;
        k = int'(v[14:11]);
        cs = 0;
        if (k > 0) cs = sp[k - 1];
        ce = sp[k];
        v = v + cs + (((ce - cs) * (v - 2048 * k)) >>> 11);
        v = ((v * og) >>> 15) + oo;
        if (v > ch) v = ch;
        if (v < cl) v = cl;
        return v[15:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] cfg;
        logic [15:0] val;
        logic [21:0] smp;
        int          sh;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk("memLocked", 1'b0, memLocked);
        chk("shortActive", 1'b0, outCtl.shortActive);
        // Round trip of the six gain, offset and clamp registers, junk in the upper half, then an unmapped place
        for (int i = 0; i < 6; i++) begin
            val = 16'($random(seed));
            wr(8'(4 * i), {16'($random(seed)), val});
            rdchk("wordReg", 8'(4 * i), val);
        end
        rdchk("unmapped", 8'h7c, 16'h0000);
        // Every short code, both supply modes, band bit set while still unlocked
        for (int i = 0; i < 4; i++) begin
            cfg = 16'h0080 | 16'(i << 8) | 16'((i & 1) << 5) | 16'((i >> 1) << 4) | 16'((i & 1) << 3);
            wr(soc_pkg::REG_CUST_CFG, {16'h0000, cfg});
            chk("shortMode", 32'(i), 32'(outCtl.shortMode));
            chk("commEnable", 32'(i >> 1), 32'(outCtl.commEnable));
            chk("ovEnable", 32'(~i & 1), 32'(outCtl.ovEnable));
            chk("underMv", (i & 1) ? soc_pkg::UV_NORM_MV : soc_pkg::UV_EXT_MV, supplyTh.underMv);
            chk("overMv", (i & 1) ? soc_pkg::OV_NORM_MV : soc_pkg::OV_EXT_MV, supplyTh.overMv);
            chk("bandLow", 1'b0, outCtl.bandLow);
            chk("shortActive", 1'b0, outCtl.shortActive);
            rdchk("config", soc_pkg::REG_CUST_CFG, cfg);
        end
        // Signal path: first trial with neutral setpoints, then random ones with a flat top
        for (int t = 0; t < 4; t++) begin
            sh = 1 + (t % 6);
            lg = 16'($random(seed));
            lo = 16'($random(seed));
            og = 16'($urandom(seed) % 16384);
            oo = 16'(($urandom(seed) % 24576) - 8192);
            cl = 16'($urandom(seed) % 8000);
            ch = 16'(16000 + ($urandom(seed) % 16768));
            for (int n = 0; n < 16; n++) begin
                sp[n] = (t == 0 || n > 13) ? 16'sh0000 : 16'(($urandom(seed) % 129) - 64);
                wr(8'(soc_pkg::REG_LINEARIZATION_POINT_BASE + 4 * n), {16'h0000, sp[n]});
            end
            wr(soc_pkg::REG_LIN_GAIN, {16'h0000, lg});
            wr(soc_pkg::REG_LIN_OFFSET, {16'h0000, lo});
            wr(soc_pkg::REG_OUT_GAIN, {16'h0000, og});
            wr(soc_pkg::REG_OUT_OFFSET, {16'h0000, oo});
            wr(soc_pkg::REG_CLAMP_HIGH, {16'h0000, ch});
            wr(soc_pkg::REG_CLAMP_LOW, {16'h0000, cl});
            wr(soc_pkg::REG_CUST_CFG, {16'h0000, 16'(sh << 12) | 16'h0002});
            for (int j = 0; j < 10; j++) begin
                smp = (j == 0) ? 22'h1fffff : (j == 1) ? 22'h200000 : 22'($random(seed));
                filteredSample <= smp;
                repeat (6) @(posedge mclk);
                chk("outLevel", expOut(smp, sh), outLevel);
            end
        end
        // Diagnosis forcing and following, then no forcing, then latching
        for (int m = 0; m < 3; m++) begin
            cfg = (m == 0) ? 16'h0000 : (m == 1) ? 16'h0002 : 16'h0006;
            wr(soc_pkg::REG_CUST_CFG, {16'h0000, cfg});
            diagError <= 1'b1;
            repeat (4) @(posedge mclk);
            chk("errForce", (m == 0), outCtl.errForce);
            chk("diagFlag", 1'b1, diagFlag);
            diagError <= 1'b0;
            repeat (4) @(posedge mclk);
            chk("diagFlag", (m == 2), diagFlag);
            if (m == 0) chk("errForce", 1'b0, outCtl.errForce);
        end
        // Lock with low band requested, then writes must bounce off
        doReset();
        wr(soc_pkg::REG_CUST_CFG, {16'h0000, 16'h0081});
        chk("memLocked", 1'b1, memLocked);
        chk("bandLow", 1'b1, outCtl.bandLow);
        chk("shortActive", 1'b0, outCtl.shortActive);
        wr(soc_pkg::REG_CUST_CFG, {16'h0000, 16'h0300});
        wr(soc_pkg::REG_OUT_GAIN, {16'h0000, 16'h1234});
        rdchk("config", soc_pkg::REG_CUST_CFG, 16'h0081);
        rdchk("outGain", soc_pkg::REG_OUT_GAIN, 16'h0000);
        doReset();
        chk("memLocked", 1'b0, memLocked);
        chk("bandLow", 1'b0, outCtl.bandLow);
        // Overvoltage reaches the flag only while detection is on
        wr(soc_pkg::REG_CUST_CFG, {16'h0000, 16'h0000});
        overVoltage <= 1'b1;
        repeat (4) @(posedge mclk);
        chk("diagFlag", 1'b1, diagFlag);
        chk("errForce", 1'b1, outCtl.errForce);
        wr(soc_pkg::REG_CUST_CFG, {16'h0000, 16'h0008});
        repeat (4) @(posedge mclk);
        chk("diagFlag", 1'b0, diagFlag);
        chk("ovEnable", 1'b0, outCtl.ovEnable);
        overVoltage <= 1'b0;
        report_and_stop();
    end
endmodule
